/* hw/sps_mode_switch.sv */
// P/PI mode switch and torque reference filter settings block.
// Assumes a host on a plain strobe register port, same clock for all.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module sps_mode_switch #(
   parameter int DATA_W = 16
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic meas_valid,
   input wire sps_pkg::sps_meas_t meas,
   output logic p_control,
   output sps_pkg::sps_filt_t filt_cfg
);
   initial
   begin
      if (DATA_W != 16)
      begin
         $error("DATA_W must be 16");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Settings registers
   logic [2:0] sel_ff;
   logic [1:0] mode_ff;
   logic [15:0] trq_thr_ff, spd_thr_ff, acc_thr_ff, per_thr_ff;
   logic [15:0] lag_tc_ff, lag2_f_ff, lag2_q_ff;
   logic n1_en_ff, n2_en_ff;
   logic [15:0] n1_f_ff, n1_q_ff, n1_d_ff, n2_f_ff, n2_q_ff, n2_d_ff;
   logic [15:0] pint_ff;
   logic [15:0] wd;

   assign wd = reg_wdata[15:0];

   // Clamp into a range; out-of-range writes saturate rather than wrap
   function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
      logic [15:0] r;
      r = v;
      if (v < lo)
      begin
         r = lo;
      end
      else if (v > hi)
      begin
         r = hi;
      end
      return r;
   endfunction : clip

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sel_ff <= sps_pkg::SEL_TORQUE;
         mode_ff <= sps_pkg::MODE_SPEED;
      end
      else if (reg_wr && reg_addr == sps_pkg::REG_CTRL)
      begin
         if (reg_wdata[sps_pkg::CTRL_SEL_LSB +: 3] > 3'h4)
         begin
            sel_ff <= sps_pkg::SEL_NONE;
         end
         else
         begin
            sel_ff <= reg_wdata[sps_pkg::CTRL_SEL_LSB +: 3];
         end
         mode_ff <= reg_wdata[sps_pkg::CTRL_MODE_LSB +: 2];
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         trq_thr_ff <= sps_pkg::RST_TRQ_THR;
         spd_thr_ff <= sps_pkg::RST_SPD_THR;
         acc_thr_ff <= sps_pkg::RST_ACC_THR;
         per_thr_ff <= sps_pkg::RST_PER_THR;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            sps_pkg::REG_TRQ_THR: trq_thr_ff <= clip(wd, 16'h0000, sps_pkg::MAX_TRQ_THR);
            sps_pkg::REG_SPD_THR: spd_thr_ff <= clip(wd, 16'h0000, sps_pkg::MAX_SPD_THR);
            sps_pkg::REG_ACC_THR: acc_thr_ff <= clip(wd, 16'h0000, sps_pkg::MAX_ACC_THR);
            sps_pkg::REG_PER_THR: per_thr_ff <= wd;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lag_tc_ff <= sps_pkg::RST_LAG_TC;
         lag2_f_ff <= sps_pkg::RST_LAG2_F;
         lag2_q_ff <= sps_pkg::RST_LAG2_Q;
         n1_en_ff <= 1'b0;
         n2_en_ff <= 1'b0;
         n1_f_ff <= sps_pkg::RST_NOTCH_F;
         n1_q_ff <= sps_pkg::RST_NOTCH_Q;
         n1_d_ff <= sps_pkg::RST_NOTCH_D;
         n2_f_ff <= sps_pkg::RST_NOTCH_F;
         n2_q_ff <= sps_pkg::RST_NOTCH_Q;
         n2_d_ff <= sps_pkg::RST_NOTCH_D;
         pint_ff <= sps_pkg::RST_PINT;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            sps_pkg::REG_LAG_TC: lag_tc_ff <= wd;
            sps_pkg::REG_LAG2_F:
               lag2_f_ff <= clip(wd, sps_pkg::MIN_LAG2_F, sps_pkg::MAX_LAG2_F);
            sps_pkg::REG_LAG2_Q:
               lag2_q_ff <= clip(wd, sps_pkg::MIN_LAG2_Q, sps_pkg::MAX_LAG2_Q);
            sps_pkg::REG_NOTCH_EN:
            begin
               n1_en_ff <= reg_wdata[sps_pkg::NOTCH1_EN_BIT];
               n2_en_ff <= reg_wdata[sps_pkg::NOTCH2_EN_BIT];
            end
            sps_pkg::REG_N1_F:
               n1_f_ff <= clip(wd, sps_pkg::MIN_NOTCH_F, sps_pkg::MAX_NOTCH_F);
            sps_pkg::REG_N1_Q:
               n1_q_ff <= clip(wd, sps_pkg::MIN_NOTCH_Q, sps_pkg::MAX_NOTCH_Q);
            sps_pkg::REG_N1_D: n1_d_ff <= clip(wd, 16'h0000, sps_pkg::MAX_NOTCH_D);
            sps_pkg::REG_N2_F:
               n2_f_ff <= clip(wd, sps_pkg::MIN_NOTCH_F, sps_pkg::MAX_NOTCH_F);
            sps_pkg::REG_N2_Q:
               n2_q_ff <= clip(wd, sps_pkg::MIN_NOTCH_Q, sps_pkg::MAX_NOTCH_Q);
            sps_pkg::REG_N2_D: n2_d_ff <= clip(wd, 16'h0000, sps_pkg::MAX_NOTCH_D);
            sps_pkg::REG_PINT: pint_ff <= clip(wd, 16'h0000, sps_pkg::MAX_PINT);
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Switching decision, re-evaluated on every measurement sample
   function automatic logic [15:0] mag(input logic signed [15:0] v);
      logic [15:0] r;
      r = v[15] ? 16'(-v) : 16'(v);
      return r;
   endfunction : mag

   logic nxt_p;
   logic p_ff;

   always_comb
   begin
      nxt_p = 1'b0;
      case (sel_ff)
         sps_pkg::SEL_TORQUE: nxt_p = mag(meas.torque_ref) > trq_thr_ff;
         sps_pkg::SEL_SPEED: nxt_p = mag(meas.speed_ref) > spd_thr_ff;
         sps_pkg::SEL_ACCEL: nxt_p = mag(meas.accel_ref) > acc_thr_ff;
         sps_pkg::SEL_POSERR:
            nxt_p = (mode_ff == sps_pkg::MODE_POSITION) &&
                    (mag(meas.pos_err) > per_thr_ff);
         sps_pkg::SEL_NONE: nxt_p = 1'b0;
         default: nxt_p = 1'b0;
      endcase
      // Torque mode has no speed loop to switch
      if (mode_ff == sps_pkg::MODE_TORQUE)
      begin
         nxt_p = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         p_ff <= 1'b0;
      end
      else if (meas_valid)
      begin
         p_ff <= nxt_p;
      end
      else if (mode_ff == sps_pkg::MODE_TORQUE || sel_ff == sps_pkg::SEL_NONE)
      begin
         p_ff <= 1'b0;
      end
   end

   assign p_control = p_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Filter chain settings; every stage except the first lag (lag_tc) carries its own enable
   always_comb
   begin
      filt_cfg.lag_tc = lag_tc_ff;
      filt_cfg.lag2_en = (lag2_f_ff != sps_pkg::MAX_LAG2_F);
      filt_cfg.lag2_f = lag2_f_ff;
      filt_cfg.lag2_q = lag2_q_ff;
      filt_cfg.n1_en = n1_en_ff;
      filt_cfg.n1_f = n1_f_ff;
      filt_cfg.n1_q = n1_q_ff;
      filt_cfg.n1_d = n1_d_ff;
      filt_cfg.n2_en = n2_en_ff;
      filt_cfg.n2_f = n2_f_ff;
      filt_cfg.n2_q = n2_q_ff;
      filt_cfg.n2_d = n2_d_ff;
      filt_cfg.pos_int_tc = pint_ff;
      filt_cfg.pos_int_en = (mode_ff == sps_pkg::MODE_POSITION) && (pint_ff != 16'h0000);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port; unmapped addresses read zero
   logic [31:0] nxt_rdata;
   logic [31:0] rdata_ff;

   always_comb
   begin
      nxt_rdata = 32'h0000_0000;
      case (reg_addr)
         sps_pkg::REG_CTRL: nxt_rdata = {26'h0, mode_ff, 1'b0, sel_ff};
         sps_pkg::REG_TRQ_THR: nxt_rdata = {16'h0000, trq_thr_ff};
         sps_pkg::REG_SPD_THR: nxt_rdata = {16'h0000, spd_thr_ff};
         sps_pkg::REG_ACC_THR: nxt_rdata = {16'h0000, acc_thr_ff};
         sps_pkg::REG_PER_THR: nxt_rdata = {16'h0000, per_thr_ff};
         sps_pkg::REG_LAG_TC: nxt_rdata = {16'h0000, lag_tc_ff};
         sps_pkg::REG_LAG2_F: nxt_rdata = {16'h0000, lag2_f_ff};
         sps_pkg::REG_LAG2_Q: nxt_rdata = {16'h0000, lag2_q_ff};
         sps_pkg::REG_NOTCH_EN: nxt_rdata = {23'h0, n2_en_ff, 7'h00, n1_en_ff};
         sps_pkg::REG_N1_F: nxt_rdata = {16'h0000, n1_f_ff};
         sps_pkg::REG_N1_Q: nxt_rdata = {16'h0000, n1_q_ff};
         sps_pkg::REG_N1_D: nxt_rdata = {16'h0000, n1_d_ff};
         sps_pkg::REG_N2_F: nxt_rdata = {16'h0000, n2_f_ff};
         sps_pkg::REG_N2_Q: nxt_rdata = {16'h0000, n2_q_ff};
         sps_pkg::REG_N2_D: nxt_rdata = {16'h0000, n2_d_ff};
         sps_pkg::REG_PINT: nxt_rdata = {16'h0000, pint_ff};
         sps_pkg::REG_STATUS: nxt_rdata = {31'h0, p_ff};
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rdata_ff <= 32'h0000_0000;
      end
      else if (reg_rd)
      begin
         rdata_ff <= nxt_rdata;
      end
      else
      begin
         rdata_ff <= 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_ff;
endmodule : sps_mode_switch

/* pkg/sps_pkg.sv */
// Package for the P/PI mode switch and torque reference filter block.
// Assumes a single 20 MHz clock and a plain strobe register port.
package sps_pkg;
   // Register offsets (word index = byte address / 4)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TRQ_THR = 8'h04;
   localparam logic [7:0] REG_SPD_THR = 8'h08;
   localparam logic [7:0] REG_ACC_THR = 8'h0C;
   localparam logic [7:0] REG_PER_THR = 8'h10;
   localparam logic [7:0] REG_LAG_TC = 8'h14;
   localparam logic [7:0] REG_LAG2_F = 8'h18;
   localparam logic [7:0] REG_LAG2_Q = 8'h1C;
   localparam logic [7:0] REG_NOTCH_EN = 8'h20;
   localparam logic [7:0] REG_N1_F = 8'h24;
   localparam logic [7:0] REG_N1_Q = 8'h28;
   localparam logic [7:0] REG_N1_D = 8'h2C;
   localparam logic [7:0] REG_N2_F = 8'h30;
   localparam logic [7:0] REG_N2_Q = 8'h34;
   localparam logic [7:0] REG_N2_D = 8'h38;
   localparam logic [7:0] REG_PINT = 8'h3C;
   localparam logic [7:0] REG_STATUS = 8'h40;
   // Reset values
   localparam logic [15:0] RST_TRQ_THR = 16'h00C8;
   localparam logic [15:0] RST_SPD_THR = 16'h0000;
   localparam logic [15:0] RST_ACC_THR = 16'h0000;
   localparam logic [15:0] RST_PER_THR = 16'h0000;
   localparam logic [15:0] RST_LAG_TC = 16'h0064;
   localparam logic [15:0] RST_LAG2_F = 16'h1388;
   localparam logic [15:0] RST_LAG2_Q = 16'h0032;
   localparam logic [15:0] RST_NOTCH_F = 16'h1388;
   localparam logic [15:0] RST_NOTCH_Q = 16'h0046;
   localparam logic [15:0] RST_NOTCH_D = 16'h0000;
   localparam logic [15:0] RST_PINT = 16'h0000;
   // Ranges
   localparam logic [15:0] MAX_TRQ_THR = 16'h0320;
   localparam logic [15:0] MAX_SPD_THR = 16'h2710;
   localparam logic [15:0] MAX_ACC_THR = 16'h7530;
   localparam logic [15:0] MAX_LAG2_F = 16'h1388;
   localparam logic [15:0] MIN_LAG2_F = 16'h0064;
   localparam logic [15:0] MIN_LAG2_Q = 16'h0032;
   localparam logic [15:0] MAX_LAG2_Q = 16'h0064;
   localparam logic [15:0] MIN_NOTCH_F = 16'h0032;
   localparam logic [15:0] MAX_NOTCH_F = 16'h1388;
   localparam logic [15:0] MIN_NOTCH_Q = 16'h0032;
   localparam logic [15:0] MAX_NOTCH_Q = 16'h03E8;
   localparam logic [15:0] MAX_NOTCH_D = 16'h03E8;
   localparam logic [15:0] MAX_PINT = 16'hC350;
   // Field positions
   localparam int NOTCH1_EN_BIT = 0;
   localparam int NOTCH2_EN_BIT = 8;
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_MODE_LSB = 4;
   // Switch condition codes
   typedef enum logic [2:0] {
      SEL_TORQUE = 3'b000,
      SEL_SPEED = 3'b001,
      SEL_ACCEL = 3'b010,
      SEL_POSERR = 3'b011,
      SEL_NONE = 3'b100
   } sps_sel_t;
   // Control method
   typedef enum logic [1:0] {
      MODE_SPEED = 2'b00,
      MODE_POSITION = 2'b01,
      MODE_TORQUE = 2'b10
   } sps_mode_t;
   // Quantities sampled each control cycle
   typedef struct packed {
      logic signed [15:0] torque_ref;
      logic signed [15:0] speed_ref;
      logic signed [15:0] accel_ref;
      logic signed [15:0] pos_err;
   } sps_meas_t;
   // Filter settings handed to the arithmetic
   typedef struct packed {
      logic [15:0] lag_tc;
      logic lag2_en;
      logic [15:0] lag2_f;
      logic [15:0] lag2_q;
      logic n1_en;
      logic [15:0] n1_f;
      logic [15:0] n1_q;
      logic [15:0] n1_d;
      logic n2_en;
      logic [15:0] n2_f;
      logic [15:0] n2_q;
      logic [15:0] n2_d;
      logic [15:0] pos_int_tc;
      logic pos_int_en;
   } sps_filt_t;
endpackage : sps_pkg

/* test/sps_mode_switch_sva.sv */
// Port checker for the mode switch block.
// Assumes one clock; shadow thresholds saturate on write like the block.
`timescale 1ns/10ps
module sps_mode_switch_sva (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic meas_valid,
   input wire sps_pkg::sps_meas_t meas,
   input wire logic p_control,
   input wire sps_pkg::sps_filt_t filt_cfg
);
   logic [2:0] sel_ff;
   logic [1:0] mode_ff;
   logic [15:0] thr_ff [4];
   logic hit;
   function automatic logic [15:0] mag(input logic signed [15:0] v);
      return (v < 0) ? -v : v;
   endfunction : mag
   // Out-of-range threshold writes land at the range end
   function automatic logic [15:0] lim(input logic [15:0] v, input logic [15:0] hi);
      return (v > hi) ? hi : v;
   endfunction : lim
   ////////////////////////////////////////
   // Shadow of selector, mode and thresholds
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sel_ff <= 3'h0;
         mode_ff <= 2'h0;
      end
      else if (reg_wr && reg_addr == 8'h00)
      begin
         sel_ff <= (reg_wdata[2:0] > 3'h4) ? 3'h4 : reg_wdata[2:0];
         mode_ff <= reg_wdata[5:4];
      end
   end
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         thr_ff <= '{16'h00C8, 16'h0000, 16'h0000, 16'h0000};
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            8'h04: thr_ff[0] <= lim(reg_wdata[15:0], 16'h0320);
            8'h08: thr_ff[1] <= lim(reg_wdata[15:0], 16'h2710);
            8'h0C: thr_ff[2] <= lim(reg_wdata[15:0], 16'h7530);
            8'h10: thr_ff[3] <= reg_wdata[15:0];
            default: ;
         endcase
      end
   end
   always_comb
   begin
      case (sel_ff)
         3'h0: hit = mag(meas.torque_ref) > thr_ff[0];
         3'h1: hit = mag(meas.speed_ref) > thr_ff[1];
         3'h2: hit = mag(meas.accel_ref) > thr_ff[2];
         3'h3: hit = (mode_ff == 2'h1) && (mag(meas.pos_err) > thr_ff[3]);
         default: hit = 1'b0;
      endcase
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   chk_p_follows_sel: assert property (
      meas_valid && mode_ff != 2'h2 |=> p_control == $past(hit))
      else $error("p_control differs from switch condition");
   chk_torque_mode_off: assert property (
      mode_ff == 2'h2 |=> !p_control)
      else $error("p_control set in torque mode");
   chk_sel_none_off: assert property (
      sel_ff == 3'h4 |=> !p_control)
      else $error("p_control set with switching off");
   chk_lag_tc_now: assert property (
      reg_wr && reg_addr == 8'h14 |=> filt_cfg.lag_tc == $past(reg_wdata[15:0]))
      else $error("lag time constant not applied");
   chk_notch_en_now: assert property (
      reg_wr && reg_addr == 8'h20 |=>
      filt_cfg.n1_en == $past(reg_wdata[0]) && filt_cfg.n2_en == $past(reg_wdata[8]))
      else $error("notch enables not applied");
   chk_lag2_bypass: assert property (
      filt_cfg.lag2_en == (filt_cfg.lag2_f != 16'h1388))
      else $error("second lag enable wrong");
   chk_notch_ranges: assert property (
      filt_cfg.n1_f inside {[16'h0032:16'h1388]} && filt_cfg.n2_f inside {[16'h0032:16'h1388]}
      && filt_cfg.n1_q <= 16'h03E8 && filt_cfg.n2_d <= 16'h03E8)
      else $error("notch setting out of range");
   chk_pint_range: assert property (
      filt_cfg.pos_int_tc <= 16'hC350)
      else $error("position integral out of range");
endmodule : sps_mode_switch_sva
bind sps_mode_switch sps_mode_switch_sva chk (.clock(clock), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .meas_valid(meas_valid),
   .meas(meas), .p_control(p_control), .filt_cfg(filt_cfg));

/* test/sps_host_model.sv */
// Host controller model: one reference sample per control cycle.
// Assumes the bench calls send from a single process.
`timescale 1ns/10ps
module sps_host_model (
   input wire logic clock,
   output logic meas_valid,
   output sps_pkg::sps_meas_t meas
);
   initial
   begin
      meas_valid = 1'b0;
      meas = '0;
   end
   // Inverse after the pulse, so stale data never looks valid
   task automatic send(input logic [63:0] v);
      @(posedge clock);
      meas_valid <= 1'b1;
      meas <= v;
      @(posedge clock);
      meas_valid <= 1'b0;
      meas <= ~v;
   endtask : send
endmodule : sps_host_model

/* test/tb.sv */
// Self-checking bench for the mode switch block.
// Assumes checker and host model are compiled first.
`timescale 1ns/10ps
module tb;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, d;
   logic meas_valid, p_control;
   sps_pkg::sps_meas_t meas;
   sps_pkg::sps_filt_t filt_cfg;
   int n_mismatch = 0;
   int samples_checked = 0;
   always #25 clock = ~clock;
   sps_mode_switch dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .meas_valid(meas_valid), .meas(meas), .p_control(p_control), .filt_cfg(filt_cfg));
   sps_host_model host (.clock(clock), .meas_valid(meas_valid), .meas(meas));
   ////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic pulse(input logic [63:0] q);
      host.send(q);
      #1;
   endtask : pulse
   ////////////////////////////////////////
   task automatic t_defaults;
      logic [15:0] e [18] = '{16'h0, 16'h00C8, 16'h0, 16'h0, 16'h0, 16'h0064, 16'h1388,
         16'h0032, 16'h0, 16'h1388, 16'h0046, 16'h0, 16'h1388, 16'h0046, 16'h0, 16'h0,
         16'h0, 16'h0};
      foreach (e[i])
      begin
         rd(8'(4 * i));
         check("reg", d, {16'h0, e[i]});
      end
      check("enables", {29'h0, filt_cfg.lag2_en, filt_cfg.n2_en, filt_cfg.n1_en}, 0);
      $display("t_defaults done");
   endtask : t_defaults
   task automatic t_ranges;
      logic [39:0] t [9] = '{40'h04_0321_0320, 40'h08_2711_2710, 40'h0C_7531_7530,
         40'h3C_C351_C350, 40'h18_0063_0064, 40'h1C_0065_0064, 40'h28_03E9_03E8,
         40'h30_0031_0032, 40'h44_FFFF_0000};
      // Frequencies move here only while no references flow
      foreach (t[i])
      begin
         wr(t[i][39:32], {16'h0, t[i][31:16]});
         rd(t[i][39:32]);
         check("sat", d, {16'h0, t[i][15:0]});
      end
      $display("t_ranges done");
   endtask : t_ranges
   task automatic t_switch;
      logic [15:0] v [4] = '{16'h0065, 16'h0064, 16'hFF9B, 16'h0000};
      for (int s = 0; s < 4; s++)
      begin
         wr(8'h00, {26'h0, (s == 3) ? 2'h1 : 2'h0, 1'b0, 3'(s)});
         wr(8'h04 + 8'(4 * s), 32'h64);
         foreach (v[i])
         begin
            pulse(64'(v[i]) << (48 - 16 * s));
            check("p_control", {31'h0, p_control}, 32'(i % 2 == 0 && i < 3));
         end
      end
      $display("t_switch done");
   endtask : t_switch
   task automatic t_blocked;
      logic [31:0] c [3] = '{32'h03, 32'h07, 32'h20};
      foreach (c[i])
      begin
         wr(8'h00, 32'h0);
         pulse(64'h7FFF_0000_0000_7FFF);
         rd(8'h40);
         check("status", d, 32'h1);
         @(posedge clock);
         #1 check("rdata_idle", reg_rdata, 32'h0);
         wr(8'h00, c[i]);
         pulse(64'h7FFF_0000_0000_7FFF);
         check("p_off", {31'h0, p_control}, 32'h0);
      end
      $display("t_blocked done");
   endtask : t_blocked
   task automatic t_filters;
      wr(8'h20, 32'h100);
      check("notch", {30'h0, filt_cfg.n2_en, filt_cfg.n1_en}, 32'h2);
      wr(8'h20, 32'h001);
      check("notch", {30'h0, filt_cfg.n2_en, filt_cfg.n1_en}, 32'h1);
      wr(8'h14, 32'hFFFF);
      check("lag_tc", {16'h0, filt_cfg.lag_tc}, 32'hFFFF);
      // Back within the stability bound for loop gains up to about 75 Hz
      wr(8'h14, 32'h0032);
      check("lag_tc", {16'h0, filt_cfg.lag_tc}, 32'h0032);
      wr(8'h18, 32'h1388);
      check("lag2_en", {31'h0, filt_cfg.lag2_en}, 32'h0);
      wr(8'h18, 32'h1387);
      check("lag2_en", {31'h0, filt_cfg.lag2_en}, 32'h1);
      check("pint", {15'h0, filt_cfg.pos_int_en, filt_cfg.pos_int_tc}, 32'h0000C350);
      wr(8'h00, 32'h10);
      check("pint", {15'h0, filt_cfg.pos_int_en, filt_cfg.pos_int_tc}, 32'h0001C350);
      $display("t_filters done");
   endtask : t_filters
   ////////////////////////////////////////
   task automatic complete_run;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      t_defaults;
      t_ranges;
      t_switch;
      t_blocked;
      t_filters;
      complete_run;
   end
   // Run needs well under 1000 cycles
   initial
   begin
      #100000;
      n_mismatch++;
      complete_run;
   end
endmodule : tb
